// ===== inc/skip_adc_pkg.sv
`default_nettype none
package skip_adc_pkg;
    // register byte offsets on the APB port
    localparam logic [7:0] OFS_PIN_OE = 8'h00;
    localparam logic [7:0] OFS_SKIP_SET = 8'h04;
    localparam logic [7:0] OFS_BUF_XFER = 8'h08;
    localparam logic [7:0] OFS_SKIP_CNT = 8'h0C;
    localparam logic [7:0] OFS_REQ_CYC_BUF = 8'h10;
    localparam logic [7:0] OFS_REQ_CYC = 8'h14;
    localparam logic [7:0] OFS_REQ_CTRL = 8'h18;
    // reset values
    localparam logic [7:0] RST_PIN_OE = 8'hFF;
    localparam logic [7:0] RST_SKIP_SET = 8'hA0;
    localparam logic [7:0] RST_BUF_XFER = 8'h02;
    localparam logic [15:0] RST_REQ_CYC = 16'h0000;
    localparam logic [15:0] RST_REQ_CTRL = 16'h8088;
    // skip setting fields
    localparam int SKIP_CMP3A_EN_BIT = 7;
    localparam int SKIP_CMP3A_CNT_LSB = 4;
    localparam int SKIP_OVF4_EN_BIT = 3;
    localparam int SKIP_OVF4_CNT_LSB = 0;
    // skip counter register fields
    localparam int CNT_CMP3A_LSB = 4;
    localparam int CNT_OVF4_LSB = 0;
    // buffer transfer select
    localparam logic [1:0] BUF_XFER_LINKED = 2'h2;
    // request control fields, then the pin enable width
    localparam int CTRL_TIMING_LSB = 14;
    localparam logic [1:0] TIMING_AT_TROUGH = 2'h2;
    localparam int CTRL_A_UP = 7;
    localparam int CTRL_A_DOWN = 6;
    localparam int CTRL_B_UP = 5;
    localparam int CTRL_B_DOWN = 4;
    localparam int CTRL_A_CMP3A = 3;
    localparam int CTRL_A_OVF4 = 2;
    localparam int CTRL_B_CMP3A = 1;
    localparam int CTRL_B_OVF4 = 0;
    localparam int PIN_OE_BITS = 6;

    typedef struct packed {
        logic cmp3a;
        logic ovf4;
        logic trough;
        logic countUp;
        logic [15:0] ch4Counter;
    } timer_evt_t;

    typedef struct packed {
        logic [2:0] count;
        logic pass;
    } skip_cnt_t;
endpackage : skip_adc_pkg
`default_nettype wire

// ===== design/skip_counter.sv
`timescale 1ns/1ps
`default_nettype none
// one interrupt skip counter: counts events, lets one through after the skip count
module skip_counter
    import skip_adc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic enable,
    input wire logic event_i,
    input wire logic [2:0] skipCount,
    // state
    output logic [2:0] count,
    output logic passPulse
);
    skip_cnt_t st_q;
    skip_cnt_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.pass = 1'b0;
        if (enable && event_i) begin
            if (st_q.count >= skipCount) begin
                st_d.count = 3'h0;
                st_d.pass = 1'b1;
            end else begin
                st_d.count = st_q.count + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.count;
    assign passPulse = st_q.pass;

    AST_HOLD_WHEN_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        !enable |=> count == $past(count))
        else $error("skip counter moved while disabled");
    AST_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
        enable && event_i && count >= skipCount |=> count == 3'h0 && passPulse)
        else $error("skip counter did not release and restart");
    AST_STEP: assert property (@(posedge clk) disable iff (!arst_n)
        enable && event_i && count < skipCount |=> count == $past(count) + 3'h1)
        else $error("skip counter did not step by one");
    AST_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
        !(enable && event_i) |=> !passPulse)
        else $error("skip release without an event");
endmodule : skip_counter
`default_nettype wire

// ===== design/pwm_timer_skip_and_adc_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_skip_and_adc_trigger
    import skip_adc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer core events
    input wire timer_evt_t timerEvt,
    // pwm pin drive from the waveform logic
    input wire logic [5:0] pwmLevel,
    // pwm pins: ch3_b, ch4_a, ch4_b, ch3_d, ch4_c, ch4_d
    output logic [5:0] pwmPinOut,
    output logic [5:0] pwmPinOe,
    // gated interrupt requests
    output logic cmp3aInterrupt,
    output logic ovf4Interrupt,
    // duty buffer transfer strobe toward the temporary registers
    output logic dutyXferStrobe,
    // delayed converter start requests
    output logic delayedAdcReqA,
    output logic delayedAdcReqB
);
    typedef struct packed {
        logic [7:0] pinOe;
        logic [7:0] skipSet;
        logic [7:0] bufXfer;
        logic [15:0] reqCycBuf;
        logic [15:0] reqCyc;
        logic [15:0] reqCtrl;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [5:0] pinOut;
        logic [5:0] pinEn;
        logic irqA;
        logic irqV;
        logic xfer;
        logic reqA;
        logic reqB;
        logic [15:0] lastCnt;
        logic cmp3aDone;
        logic ovf4Done;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic [2:0] cmp3aCnt;
    logic [2:0] ovf4Cnt;
    logic cmp3aPass;
    logic ovf4Pass;
    logic cmp3aSkipOn;
    logic ovf4SkipOn;
    logic setupPhase;
    logic accessPhase;
    logic match;
    logic gateA;
    logic gateB;
    logic cmp3aIrqNow;
    logic ovf4IrqNow;

    assign cmp3aSkipOn = st_q.skipSet[SKIP_CMP3A_EN_BIT];
    assign ovf4SkipOn = st_q.skipSet[SKIP_OVF4_EN_BIT];

    skip_counter u_cmp3a_skip (
        .clk(clk),
        .arst_n(arst_n),
        .enable(cmp3aSkipOn),
        .event_i(timerEvt.cmp3a),
        .skipCount(st_q.skipSet[SKIP_CMP3A_CNT_LSB +: 3]),
        .count(cmp3aCnt),
        .passPulse(cmp3aPass)
    );

    skip_counter u_ovf4_skip (
        .clk(clk),
        .arst_n(arst_n),
        .enable(ovf4SkipOn),
        .event_i(timerEvt.ovf4),
        .skipCount(st_q.skipSet[SKIP_OVF4_CNT_LSB +: 3]),
        .count(ovf4Cnt),
        .passPulse(ovf4Pass)
    );

    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    // a match counts only when the counter steps onto the set value, not while parked
    assign match = timerEvt.ch4Counter == st_q.reqCyc && st_q.lastCnt != st_q.reqCyc;

    // interrupts pass directly when skipping is off, else on the counter release
    assign cmp3aIrqNow = cmp3aSkipOn ? cmp3aPass : timerEvt.cmp3a;
    assign ovf4IrqNow = ovf4SkipOn ? ovf4Pass : timerEvt.ovf4;

    always_comb begin
        gateA = timerEvt.countUp ? st_q.reqCtrl[CTRL_A_UP]
                                 : st_q.reqCtrl[CTRL_A_DOWN];
        gateB = timerEvt.countUp ? st_q.reqCtrl[CTRL_B_UP]
                                 : st_q.reqCtrl[CTRL_B_DOWN];
        // linkage: the request waits for the latest skip release of the linked source
        if (st_q.reqCtrl[CTRL_A_CMP3A] && !st_q.cmp3aDone) begin
            gateA = 1'b0;
        end
        if (st_q.reqCtrl[CTRL_A_OVF4] && !st_q.ovf4Done) begin
            gateA = 1'b0;
        end
        if (st_q.reqCtrl[CTRL_B_CMP3A] && !st_q.cmp3aDone) begin
            gateB = 1'b0;
        end
        if (st_q.reqCtrl[CTRL_B_OVF4] && !st_q.ovf4Done) begin
            gateB = 1'b0;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.ready = 1'b0;
        st_d.err = 1'b0;
        st_d.lastCnt = timerEvt.ch4Counter;

        // apb: decode in setup, answer one cycle later in the access phase
        if (setupPhase) begin
            st_d.ready = 1'b1;
            st_d.rdata = 32'h0000_0000;
            unique case (paddr)
                OFS_PIN_OE: st_d.rdata = {24'h00_0000, st_q.pinOe};
                OFS_SKIP_SET: st_d.rdata = {24'h00_0000, st_q.skipSet};
                OFS_BUF_XFER: st_d.rdata = {24'h00_0000, st_q.bufXfer};
                OFS_SKIP_CNT: st_d.rdata = {24'h00_0000, 1'b0, cmp3aCnt, 1'b0, ovf4Cnt};
                OFS_REQ_CYC_BUF: st_d.rdata = {16'h0000, st_q.reqCycBuf};
                OFS_REQ_CYC: st_d.rdata = {16'h0000, st_q.reqCyc};
                OFS_REQ_CTRL: st_d.rdata = {16'h0000, st_q.reqCtrl};
                default: st_d.err = 1'b1;
            endcase
            if (pwrite) begin
                st_d.rdata = 32'h0000_0000;
            end
        end
        if (accessPhase && st_q.ready && pwrite) begin
            unique case (paddr)
                OFS_PIN_OE: st_d.pinOe = pwdata[7:0];
                OFS_SKIP_SET: st_d.skipSet = pwdata[7:0];
                OFS_BUF_XFER: st_d.bufXfer = {6'h00, pwdata[1:0]};
                OFS_REQ_CYC_BUF: st_d.reqCycBuf = pwdata[15:0];
                OFS_REQ_CYC: st_d.reqCyc = pwdata[15:0];
                OFS_REQ_CTRL: st_d.reqCtrl = {pwdata[15:14], 6'h00, pwdata[7:0]};
                default: ;
            endcase
        end

        // buffered timing: copy at each trough when the select says so
        if (timerEvt.trough
                && st_q.reqCtrl[CTRL_TIMING_LSB +: 2] == TIMING_AT_TROUGH) begin
            st_d.reqCyc = st_q.reqCycBuf;
        end

        // pin drive: the level always follows, the enable decides who owns the pin
        st_d.pinOut = pwmLevel;
        st_d.pinEn = st_q.pinOe[PIN_OE_BITS-1:0];

        st_d.irqA = cmp3aIrqNow;
        st_d.irqV = ovf4IrqNow;

        // duty transfer: every trough normally, only on released skips when linked
        if (st_q.bufXfer[1:0] == BUF_XFER_LINKED) begin
            st_d.xfer = (cmp3aSkipOn && cmp3aIrqNow) || (ovf4SkipOn && ovf4IrqNow);
        end else begin
            st_d.xfer = timerEvt.trough;
        end

        // release memory: set wins over the clear made by a counter match
        if (match) begin
            st_d.cmp3aDone = 1'b0;
            st_d.ovf4Done = 1'b0;
        end
        if (cmp3aSkipOn && cmp3aPass) begin
            st_d.cmp3aDone = 1'b1;
        end
        if (ovf4SkipOn && ovf4Pass) begin
            st_d.ovf4Done = 1'b1;
        end

        st_d.reqA = match && gateA;
        st_d.reqB = match && gateB;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
            st_q.pinOe <= RST_PIN_OE;
            st_q.pinEn <= RST_PIN_OE[PIN_OE_BITS-1:0];
            st_q.skipSet <= RST_SKIP_SET;
            st_q.bufXfer <= RST_BUF_XFER;
            st_q.reqCycBuf <= RST_REQ_CYC;
            st_q.reqCyc <= RST_REQ_CYC;
            st_q.reqCtrl <= RST_REQ_CTRL;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.err;
    assign pwmPinOut = st_q.pinOut;
    assign pwmPinOe = st_q.pinEn;
    assign cmp3aInterrupt = st_q.irqA;
    assign ovf4Interrupt = st_q.irqV;
    assign dutyXferStrobe = st_q.xfer;
    assign delayedAdcReqA = st_q.reqA;
    assign delayedAdcReqB = st_q.reqB;

    sequence s_trough_copy;
        timerEvt.trough && st_q.reqCtrl[15:14] == TIMING_AT_TROUGH;
    endsequence

    AST_PIN_OE: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 pwmPinOe == $past(st_q.pinOe[5:0]))
        else $error("pin enable not following register");
    // with skipping on the gated request lags the event by two cycles
    AST_CMP3A_SKIPPED: assert property (@(posedge clk) disable iff (!arst_n)
        cmp3aSkipOn && timerEvt.cmp3a && cmp3aCnt < st_q.skipSet[6:4]
        |=> cmp3aSkipOn |=> !cmp3aInterrupt)
        else $error("compare-A interrupt not skipped");
    AST_OVF4_DIRECT: assert property (@(posedge clk) disable iff (!arst_n)
        !ovf4SkipOn && timerEvt.ovf4 |=> ovf4Interrupt)
        else $error("overflow interrupt lost with skipping off");
    AST_TROUGH_COPY: assert property (@(posedge clk) disable iff (!arst_n)
        s_trough_copy |=> st_q.reqCyc == $past(st_q.reqCycBuf))
        else $error("buffer not copied at trough");
    AST_A_DOWN_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
        !timerEvt.countUp && !st_q.reqCtrl[6] |=> !delayedAdcReqA)
        else $error("request A issued while counting down");
    AST_B_UP_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
        timerEvt.countUp && !st_q.reqCtrl[5] |=> !delayedAdcReqB)
        else $error("request B issued while counting up");
    AST_B_DOWN_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
        !timerEvt.countUp && !st_q.reqCtrl[4] |=> !delayedAdcReqB)
        else $error("request B issued while counting down");
    AST_A_UP_FIRE: assert property (@(posedge clk) disable iff (!arst_n)
        match && timerEvt.countUp && st_q.reqCtrl[7:2] == 6'h20 |=> delayedAdcReqA)
        else $error("request A missing on upward match");
    AST_APB_ONE_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
        setupPhase |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    // unlinked requests: a match with its direction bit open must issue
    sequence s_a_up_open;
        match && timerEvt.countUp && st_q.reqCtrl[CTRL_A_UP]
            && st_q.reqCtrl[CTRL_A_OVF4 +: 2] == 2'b00;
    endsequence

    sequence s_a_down_open;
        match && !timerEvt.countUp && st_q.reqCtrl[CTRL_A_DOWN]
            && st_q.reqCtrl[CTRL_A_OVF4 +: 2] == 2'b00;
    endsequence

    sequence s_b_up_open;
        match && timerEvt.countUp && st_q.reqCtrl[CTRL_B_UP]
            && st_q.reqCtrl[CTRL_B_OVF4 +: 2] == 2'b00;
    endsequence

    sequence s_b_down_open;
        match && !timerEvt.countUp && st_q.reqCtrl[CTRL_B_DOWN]
            && st_q.reqCtrl[CTRL_B_OVF4 +: 2] == 2'b00;
    endsequence

    AST_A_UP_UNLINKED: assert property (@(posedge clk) disable iff (!arst_n)
        s_a_up_open |=> delayedAdcReqA)
        else $error("request A held back with no link set");
    AST_A_DOWN_FIRE: assert property (@(posedge clk) disable iff (!arst_n)
        s_a_down_open |=> delayedAdcReqA)
        else $error("request A missing on downward match");
    AST_B_UP_FIRE: assert property (@(posedge clk) disable iff (!arst_n)
        s_b_up_open |=> delayedAdcReqB)
        else $error("request B missing on upward match");
    AST_B_DOWN_FIRE: assert property (@(posedge clk) disable iff (!arst_n)
        s_b_down_open |=> delayedAdcReqB)
        else $error("request B missing on downward match");

    // blocking and linkage
    AST_A_UP_BLOCK: assert property (@(posedge clk) disable iff (!arst_n)
        timerEvt.countUp && !st_q.reqCtrl[CTRL_A_UP] |=> !delayedAdcReqA)
        else $error("request A issued while counting up");
    AST_A_CMP3A_LINK: assert property (@(posedge clk) disable iff (!arst_n)
        st_q.reqCtrl[CTRL_A_CMP3A] && !st_q.cmp3aDone |=> !delayedAdcReqA)
        else $error("request A issued without a compare-A release");
    AST_B_CMP3A_LINK: assert property (@(posedge clk) disable iff (!arst_n)
        st_q.reqCtrl[CTRL_B_CMP3A] && !st_q.cmp3aDone |=> !delayedAdcReqB)
        else $error("request B issued without a compare-A release");
    AST_REQ_ONLY_ON_MATCH: assert property (@(posedge clk) disable iff (!arst_n)
        !match |=> !delayedAdcReqA && !delayedAdcReqB)
        else $error("converter request without a counter match");

    // a parked counter must not re-trigger unless the set value moved
    AST_MATCH_ONCE: assert property (@(posedge clk) disable iff (!arst_n)
        match |=> !match || $changed(st_q.reqCyc))
        else $error("match repeated on a parked counter");
    AST_CYC_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        !(timerEvt.trough && st_q.reqCtrl[CTRL_TIMING_LSB +: 2] == TIMING_AT_TROUGH)
        && !(accessPhase && st_q.ready && pwrite && paddr == OFS_REQ_CYC)
        |=> st_q.reqCyc == $past(st_q.reqCyc))
        else $error("request cycle moved with no write and no trough copy");

    // skip release and duty strobe
    AST_CMP3A_RELEASE: assert property (@(posedge clk) disable iff (!arst_n)
        cmp3aSkipOn && cmp3aPass |=> cmp3aInterrupt)
        else $error("released compare-A interrupt lost");
    AST_OVF4_SKIPPED: assert property (@(posedge clk) disable iff (!arst_n)
        ovf4SkipOn && timerEvt.ovf4 && ovf4Cnt < st_q.skipSet[SKIP_OVF4_CNT_LSB +: 3]
        |=> ovf4SkipOn |=> !ovf4Interrupt)
        else $error("overflow interrupt not skipped");
    AST_DUTY_LINKED: assert property (@(posedge clk) disable iff (!arst_n)
        st_q.bufXfer[1:0] == BUF_XFER_LINKED && !cmp3aPass && !ovf4Pass
        |=> !dutyXferStrobe)
        else $error("duty transfer outside a skip release");
    AST_DUTY_TROUGH: assert property (@(posedge clk) disable iff (!arst_n)
        st_q.bufXfer[1:0] != BUF_XFER_LINKED
        |=> dutyXferStrobe == $past(timerEvt.trough))
        else $error("duty transfer not on trough");
endmodule : pwm_timer_skip_and_adc_trigger
`default_nettype wire

// ===== testbench/adc_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: converter trigger input and interrupt controller, each pulse counted once
module adc_irq_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // pulses from the block
    input wire logic reqA,
    input wire logic reqB,
    input wire logic irq3,
    input wire logic irq4,
    input wire logic duty,
    // running counts {reqA, reqB, irq3, irq4, duty}, one byte each
    output logic [39:0] counts
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counts <= '0;
        end else begin
            counts <= counts + {7'h00, reqA, 7'h00, reqB, 7'h00, irq3, 7'h00, irq4, 7'h00, duty};
        end
    end
endmodule : adc_irq_model
`default_nettype wire

// ===== testbench/tb_pwm_timer_skip_and_adc_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_timer_skip_and_adc_trigger import skip_adc_pkg::*; ;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    timer_evt_t timerEvt;
    logic [5:0] pwmLevel, pwmPinOut, pwmPinOe;
    logic cmp3aInterrupt, ovf4Interrupt, dutyXferStrobe, delayedAdcReqA, delayedAdcReqB;
    logic [39:0] counts, snapVal;
    int errCount, compares;
    logic [7:0] ofsTab [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    logic [15:0] rstTab [7] = '{16'h00FF, 16'h00A0, 16'h0002, 16'h0000, 16'h0000, 16'h0000,
        16'h0000};
    // {control, count up, expect A, expect B}
    logic [18:0] reqTab [10] = '{{16'h80F0, 3'b111}, {16'h80F0, 3'b011}, {16'h8000, 3'b100},
        {16'h8000, 3'b000}, {16'h8080, 3'b110}, {16'h8080, 3'b000}, {16'h8040, 3'b010},
        {16'h8020, 3'b101}, {16'h8010, 3'b001}, {16'h8010, 3'b100}};

    pwm_timer_skip_and_adc_trigger pwm_timer_skip_and_adc_trigger_i (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerEvt(timerEvt),
        .pwmLevel(pwmLevel), .pwmPinOut(pwmPinOut), .pwmPinOe(pwmPinOe),
        .cmp3aInterrupt(cmp3aInterrupt), .ovf4Interrupt(ovf4Interrupt),
        .dutyXferStrobe(dutyXferStrobe), .delayedAdcReqA(delayedAdcReqA),
        .delayedAdcReqB(delayedAdcReqB));
    adc_irq_model adc_irq_model_i (.clk(clk), .arst_n(arst_n), .reqA(delayedAdcReqA),
        .reqB(delayedAdcReqB), .irq3(cmp3aInterrupt), .irq4(ovf4Interrupt),
        .duty(dutyXferStrobe), .counts(counts));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [39:0] e, input logic [39:0] got);
        compares++;
        if (got !== e) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, e, got);
        end
    endtask : chk

    // request held until the rising edge that samples pready high; answer taken there
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // read right after the edge, before the design's update of that edge lands
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errCount++;
            end_of_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, {8'h00, e}, {8'h00, rd});
        chk("slverr", {39'h0, a > 8'h18}, {39'h0, err});
    endtask : rdchk

    // event mask {cmp3a, ovf4, trough}, each a one-cycle pulse
    task automatic evt(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge clk);
            {timerEvt.cmp3a, timerEvt.ovf4, timerEvt.trough} <= m;
            @(posedge clk);
            {timerEvt.cmp3a, timerEvt.ovf4, timerEvt.trough} <= 3'h0;
        end
        repeat (3) @(posedge clk);
    endtask : evt

    task automatic match(input logic up);
        @(posedge clk);
        timerEvt.countUp <= up;
        timerEvt.ch4Counter <= 16'h0000;
        @(posedge clk);
        timerEvt.ch4Counter <= 16'h0055;
        @(posedge clk);
        timerEvt.ch4Counter <= 16'h0001;
        repeat (3) @(posedge clk);
    endtask : match

    task automatic pulses(input logic [39:0] e);
        chk("pulse counts", e, counts - snapVal);
        snapVal = counts;
    endtask : pulses

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        timerEvt = '0;
        timerEvt.ch4Counter = 16'h0001;
        pwmLevel = 6'h2A;
        errCount = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        chk("pin enable", 40'h3F, {34'h0, pwmPinOe});
        arst_n <= 1'b1;
        snapVal = counts;
        wr(OFS_SKIP_CNT, 32'hFF);
        for (int i = 0; i < 7; i++) rdchk("reset value", ofsTab[i], {16'h0, rstTab[i]});
        rdchk("control", OFS_REQ_CTRL, 32'h8088);
        wr(OFS_PIN_OE, 32'h15);
        repeat (2) @(posedge clk);
        chk("pin enable", 40'h15, {34'h0, pwmPinOe});
        chk("pin level", 40'h2A, {34'h0, pwmPinOut});
        // skip count 2 lets every third compare-A through
        evt(3'b100, 1);
        rdchk("skip counter", OFS_SKIP_CNT, 32'h10);
        evt(3'b100, 5);
        pulses(40'h0000020002);
        rdchk("skip counter", OFS_SKIP_CNT, 32'h00);
        evt(3'b010, 3);
        pulses(40'h0000000300);
        rdchk("skip counter", OFS_SKIP_CNT, 32'h00);
        wr(OFS_SKIP_SET, 32'h89);
        evt(3'b010, 1);
        rdchk("skip counter", OFS_SKIP_CNT, 32'h01);
        evt(3'b010, 3);
        pulses(40'h0000000202);
        wr(OFS_BUF_XFER, 32'h0);
        wr(OFS_REQ_CYC_BUF, 32'h55);
        evt(3'b001, 1);
        rdchk("request cycle", OFS_REQ_CYC, 32'h55);
        pulses(40'h0000000001);
        // timing select 00: a trough must leave the active value alone
        wr(OFS_REQ_CTRL, 32'h0088);
        wr(OFS_REQ_CYC_BUF, 32'h66);
        evt(3'b001, 1);
        rdchk("request cycle", OFS_REQ_CYC, 32'h55);
        pulses(40'h0000000001);
        wr(OFS_BUF_XFER, 32'h2);
        wr(OFS_SKIP_SET, 32'h80);
        for (int i = 0; i < 10; i++) begin
            wr(OFS_REQ_CTRL, {16'h0, reqTab[i][18:3]});
            match(reqTab[i][2]);
            pulses({7'h0, reqTab[i][1], 7'h0, reqTab[i][0], 24'h0});
        end
        // linked requests wait for a released compare-A since the previous match
        wr(OFS_REQ_CTRL, 32'h80AA);
        match(1'b1);
        snapVal = counts;
        match(1'b1);
        pulses(40'h0);
        evt(3'b100, 1);
        match(1'b1);
        pulses(40'h0101010001);
        end_of_test();
    end
endmodule : tb_pwm_timer_skip_and_adc_trigger
`default_nettype wire
